// ---- vapc_pkg.sv ----
// Package: register map, bit positions and reset values for the path regs
package vapc_pkg;
   localparam logic [7:0] VAPC_ADDR_DATA_PATH = 8'h22;
   localparam logic [7:0] VAPC_ADDR_GEN_PURP = 8'h23;
   localparam logic [7:0] VAPC_DP_RESET = 8'h00;
   localparam logic [7:0] VAPC_GP_RESET = 8'h10;
   localparam int VAPC_DP_HOLD = 7;
   localparam int VAPC_DP_RAW = 6;
   localparam int VAPC_DP_DEPOL = 5;
   localparam int VAPC_DP_AUD_SUP = 4;
   localparam int VAPC_DP_CHB_SRC = 3;
   localparam int VAPC_DP_W18 = 2;
   localparam int VAPC_DP_XPORT = 1;
   localparam int VAPC_DP_CHB_EN = 0;
   localparam int VAPC_GP_CKSUM = 7;
   localparam int VAPC_GP_STRAP_DONE = 4;
   localparam int VAPC_GP_LOWFREQ = 3;
   localparam int VAPC_GP_REPEATER = 2;
   localparam int VAPC_GP_BACKCOMPAT = 1;
   localparam int VAPC_GP_CHB = 0;
   localparam logic [6:0] VAPC_FC_MASK = 7'h7F;
endpackage : vapc_pkg

// ---- vapc_regs.sv ----
// Module: data path control and general purpose control registers
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Hold bit set blocks forward channel loads, keeping local values.
// - Hold clear: low seven bits overwritten by forward channel values.
// - Raw passthrough outputs pixels regardless of data enable.
// - Raw passthrough suppresses packetized audio.
// - Polarity bit 1 makes data enable active low, idle high.
// - Audio suppress 0 puts packet audio on pixel pins; 1 blocks it.
// - Channel two enable source: bit 0 when set, strap pin when clear.
// - Width bit 1 selects 18-bit video, 0 selects 24-bit.
// - Transport bit 1 carries audio in frame, 0 uses data island.
// - Channel two enable drives second audio data on blue bit 1 pin.
// - Checksum enable bit turns on per-line one-byte checksum check.
// - A checksum mismatch is latched in the link status register only while checksum enable is set, and stays until the next general register write.
// - General register shows strap done bit 4, low frequency bit 3.
// - Shows repeater bit 2, backward compat bit 1, channel two bit 0.
module vapc_regs (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // Forward channel configuration from the remote serializer
   input wire logic fc_load_in,
   input wire logic [6:0] fc_data_in,
   // Strap and mode status pins
   input wire logic mode_sel_pin_in,
   input wire logic strap_done_in,
   input wire logic low_freq_status_in,
   input wire logic repeater_in,
   input wire logic backcompat_in,
   // Line checksum events from the datapath
   input wire logic cksum_mismatch_in,
   // Configuration to the datapath
   output logic raw_pixel_passthrough_out,
   output logic data_enable_active_low_out,
   output logic pixel_audio_en_out,
   output logic video_18bit_out,
   output logic audio_in_frame_out,
   output logic blue_bit1_pin_audio_out,
   output logic cksum_check_en_out,
   output logic link_status_reg_cksum_err_out
);
   import vapc_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] dp;
      logic cksum_en;
      logic [2:0] mode_s1;
      logic [2:0] mode_s2;
      logic [2:0] mode_s3;
      logic [2:0] mode_flt;
      logic cksum_err;
   } vapc_state_t;

   vapc_state_t st_ff;
   vapc_state_t nxt_st;
   logic [2:0] mode_pins;
   logic chb_en;

   // Strap done, low freq, channel two strap pass three stage flops and a filter flop
   assign mode_pins = {strap_done_in, low_freq_status_in, mode_sel_pin_in};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.mode_s1 = mode_pins;
      nxt_st.mode_s2 = st_ff.mode_s1;
      nxt_st.mode_s3 = st_ff.mode_s2;
      // Second and third stages must agree before a change is seen;
      // while they differ the filtered value holds, so a glitch is lost
      nxt_st.mode_flt = (st_ff.mode_s2 & st_ff.mode_s3) |
                        (st_ff.mode_flt & (st_ff.mode_s2 | st_ff.mode_s3));
      if (reg_wr_in && reg_addr_in == VAPC_ADDR_DATA_PATH) begin
         nxt_st.dp = reg_wdata_in;
      end
      // Remote load wins over a local write in the same cycle for bits 6:0; bit 7 keeps the written value
      if (fc_load_in && !st_ff.dp[VAPC_DP_HOLD]) begin
         nxt_st.dp[6:0] = fc_data_in & VAPC_FC_MASK;
      end
      if (reg_wr_in && reg_addr_in == VAPC_ADDR_GEN_PURP) begin
         nxt_st.cksum_en = reg_wdata_in[VAPC_GP_CKSUM];
      end
      // Sticky error: any write to general register clears, set wins
      if (reg_wr_in && reg_addr_in == VAPC_ADDR_GEN_PURP) begin
         nxt_st.cksum_err = 1'b0;
      end
      if (cksum_mismatch_in && st_ff.cksum_en) begin
         nxt_st.cksum_err = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_ff <= '0;
         st_ff.dp <= VAPC_DP_RESET;
         st_ff.cksum_en <= VAPC_GP_RESET[VAPC_GP_CKSUM];
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic [2:0] mode_q;
   assign mode_q = st_ff.mode_flt;

   assign chb_en = st_ff.dp[VAPC_DP_CHB_SRC] ? st_ff.dp[VAPC_DP_CHB_EN]
                                             : mode_q[0];
   assign raw_pixel_passthrough_out = st_ff.dp[VAPC_DP_RAW];
   assign data_enable_active_low_out = st_ff.dp[VAPC_DP_DEPOL];
   // Passthrough blocks packet audio whatever the suppress bit says
   assign pixel_audio_en_out = !st_ff.dp[VAPC_DP_AUD_SUP] &&
                               !st_ff.dp[VAPC_DP_RAW];
   assign video_18bit_out = st_ff.dp[VAPC_DP_W18];
   assign audio_in_frame_out = st_ff.dp[VAPC_DP_XPORT];
   assign blue_bit1_pin_audio_out = chb_en;
   assign cksum_check_en_out = st_ff.cksum_en;
   assign link_status_reg_cksum_err_out = st_ff.cksum_err;

   always_comb begin
      reg_rdata_out = 8'h00;
      if (reg_addr_in == VAPC_ADDR_DATA_PATH) begin
         reg_rdata_out = st_ff.dp;
      end else if (reg_addr_in == VAPC_ADDR_GEN_PURP) begin
         reg_rdata_out[VAPC_GP_CKSUM] = st_ff.cksum_en;
         reg_rdata_out[VAPC_GP_STRAP_DONE] = mode_q[2];
         reg_rdata_out[VAPC_GP_LOWFREQ] = mode_q[1];
         reg_rdata_out[VAPC_GP_REPEATER] = repeater_in;
         reg_rdata_out[VAPC_GP_BACKCOMPAT] = backcompat_in;
         reg_rdata_out[VAPC_GP_CHB] = chb_en;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_hold_blocks;
      @(posedge clk_in) disable iff (!nrst_in)
      (st_ff.dp[VAPC_DP_HOLD] && !reg_wr_in) |=> $stable(st_ff.dp);
   endproperty
   a_hold_blocks: assert property (p_hold_blocks)
      else $error("forward load changed held register");

   property p_fc_load;
      @(posedge clk_in) disable iff (!nrst_in)
      (fc_load_in && !st_ff.dp[VAPC_DP_HOLD]) |=>
         st_ff.dp[6:0] == $past(fc_data_in);
   endproperty
   a_fc_load: assert property (p_fc_load)
      else $error("forward channel value not loaded");

   property p_raw_audio;
      @(posedge clk_in) disable iff (!nrst_in)
      raw_pixel_passthrough_out |-> !pixel_audio_en_out;
   endproperty
   a_raw_audio: assert property (p_raw_audio)
      else $error("audio present during passthrough");

   property p_aud_sup;
      @(posedge clk_in) disable iff (!nrst_in)
      st_ff.dp[VAPC_DP_AUD_SUP] |-> !pixel_audio_en_out;
   endproperty
   a_aud_sup: assert property (p_aud_sup)
      else $error("suppressed audio reaches pixel pins");

   property p_chb_src;
      @(posedge clk_in) disable iff (!nrst_in)
      st_ff.dp[VAPC_DP_CHB_SRC] |->
         blue_bit1_pin_audio_out == st_ff.dp[VAPC_DP_CHB_EN];
   endproperty
   a_chb_src: assert property (p_chb_src)
      else $error("channel two enable source wrong");

   property p_cksum_err;
      @(posedge clk_in) disable iff (!nrst_in)
      (cksum_mismatch_in && cksum_check_en_out) |=>
         link_status_reg_cksum_err_out;
   endproperty
   a_cksum_err: assert property (p_cksum_err)
      else $error("checksum mismatch not reported");

   property p_cksum_en;
      @(posedge clk_in) disable iff (!nrst_in)
      (reg_wr_in && reg_addr_in == VAPC_ADDR_GEN_PURP) |=>
         cksum_check_en_out == $past(reg_wdata_in[VAPC_GP_CKSUM]);
   endproperty
   a_cksum_en: assert property (p_cksum_en)
      else $error("checksum enable not written");

   property p_rsvd;
      @(posedge clk_in) disable iff (!nrst_in)
      (reg_addr_in == VAPC_ADDR_GEN_PURP) |-> reg_rdata_out[6:5] == 2'b00;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bits not zero");

   property p_raw_load;
      @(posedge clk_in) disable iff (!nrst_in)
      (fc_load_in && !st_ff.dp[VAPC_DP_HOLD]) |=>
         raw_pixel_passthrough_out == $past(fc_data_in[VAPC_DP_RAW]);
   endproperty
   a_raw_load: assert property (p_raw_load)
      else $error("passthrough not taken from forward load");

   property p_depol;
      @(posedge clk_in) disable iff (!nrst_in)
      (reg_wr_in && reg_addr_in == VAPC_ADDR_DATA_PATH && !fc_load_in) |=>
         data_enable_active_low_out == $past(reg_wdata_in[VAPC_DP_DEPOL]);
   endproperty
   a_depol: assert property (p_depol)
      else $error("enable polarity not written");

   property p_w18;
      @(posedge clk_in) disable iff (!nrst_in)
      (fc_load_in && !st_ff.dp[VAPC_DP_HOLD]) |=>
         video_18bit_out == $past(fc_data_in[VAPC_DP_W18]);
   endproperty
   a_w18: assert property (p_w18)
      else $error("video width not taken from forward load");

   property p_xport;
      @(posedge clk_in) disable iff (!nrst_in)
      (fc_load_in && !st_ff.dp[VAPC_DP_HOLD]) |=>
         audio_in_frame_out == $past(fc_data_in[VAPC_DP_XPORT]);
   endproperty
   a_xport: assert property (p_xport)
      else $error("audio transport not taken from forward load");

   property p_sync;
      @(posedge clk_in) disable iff (!nrst_in)
      (st_ff.mode_s2 == st_ff.mode_s3) |=>
         st_ff.mode_flt == $past(st_ff.mode_s2);
   endproperty
   a_sync: assert property (p_sync)
      else $error("agreed strap level not taken");

endmodule : vapc_regs
`default_nettype wire

// ---- vapc_fc_model.sv ----
// Forward channel configuration sender standing in for the serializer
`timescale 1ns/1ps
`default_nettype none
module vapc_fc_model (
   // Clock
   input wire logic clk_in,
   // Configuration load toward the deserializer
   output logic fc_load_out,
   output logic [6:0] fc_data_out
);
   initial begin
      fc_load_out = 1'b0;
      fc_data_out = 7'h00;
   end
   // Idle data is inverted so a stale value can never pass for a load
   task send(input logic [6:0] d);
      @(negedge clk_in);
      fc_load_out = 1'b1;
      fc_data_out = d;
      @(negedge clk_in);
      fc_load_out = 1'b0;
      fc_data_out = ~d;
   endtask : send
endmodule : vapc_fc_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the data path and general purpose registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import vapc_pkg::*;
   logic clk_in, nrst_in, reg_wr_in, fc_load_in, cksum_mismatch_in;
   logic mode_sel_pin_in, strap_done_in, low_freq_status_in;
   logic repeater_in, backcompat_in;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic [6:0] fc_data_in;
   logic raw, delow, pae, v18, aif, blue, ck_en, ck_err;
   wire logic [7:0] outs = {ck_err, ck_en, raw, delow, pae, v18, aif, blue};
   int miscompares = 0;
   int checked = 0;
   vapc_regs vapc_regs_i (.clk_in(clk_in), .nrst_in(nrst_in),
      .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .fc_load_in(fc_load_in), .fc_data_in(fc_data_in),
      .mode_sel_pin_in(mode_sel_pin_in), .strap_done_in(strap_done_in),
      .low_freq_status_in(low_freq_status_in), .repeater_in(repeater_in),
      .backcompat_in(backcompat_in), .cksum_mismatch_in(cksum_mismatch_in),
      .raw_pixel_passthrough_out(raw), .data_enable_active_low_out(delow),
      .pixel_audio_en_out(pae), .video_18bit_out(v18),
      .audio_in_frame_out(aif), .blue_bit1_pin_audio_out(blue),
      .cksum_check_en_out(ck_en), .link_status_reg_cksum_err_out(ck_err));
   vapc_fc_model vapc_fc_model_i (.clk_in(clk_in),
      .fc_load_out(fc_load_in), .fc_data_out(fc_data_in));
   task chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
   endtask : wr
   // The mask picks the bits that a read is judged on
   task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(negedge clk_in);
      reg_addr_in = a;
      #1;
      chk(reg_rdata_out & m, e);
   endtask : rd
   task fc(input logic [6:0] d, input logic [7:0] e);
      vapc_fc_model_i.send(d);
      #1;
      chk(outs & 8'h3F, e);
   endtask : fc
   task mm(input logic [7:0] e);
      @(negedge clk_in);
      cksum_mismatch_in = 1'b1;
      @(negedge clk_in);
      cksum_mismatch_in = 1'b0;
      #1;
      chk(outs & 8'hC0, e);
   endtask : mm
   task end_sim;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   initial begin
      #100us;
      miscompares++;
      end_sim;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {nrst_in, reg_wr_in, cksum_mismatch_in, mode_sel_pin_in} = 4'h0;
      {low_freq_status_in, repeater_in, backcompat_in} = 3'h0;
      strap_done_in = 1'b1;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      repeat (3) @(negedge clk_in);
      nrst_in = 1'b1;
      repeat (4) @(negedge clk_in);
      rd(VAPC_ADDR_DATA_PATH, 8'hFF, VAPC_DP_RESET);
      rd(VAPC_ADDR_GEN_PURP, 8'hFF, VAPC_GP_RESET);
      rd(8'h24, 8'hFF, 8'h00);
      fc(7'h55, 8'h24);
      fc(7'h2A, 8'h1A);
      fc(7'h09, 8'h09);
      fc(7'h10, 8'h00);
      fc(7'h40, 8'h20);
      mode_sel_pin_in = 1'b1;
      repeat (4) @(negedge clk_in);
      fc(7'h08, 8'h08);
      fc(7'h10, 8'h01);
      rd(VAPC_ADDR_DATA_PATH, 8'hFF, 8'h10);
      wr(VAPC_ADDR_DATA_PATH, 8'h80);
      fc(7'h7F, 8'h09);
      rd(VAPC_ADDR_DATA_PATH, 8'hFF, 8'h80);
      wr(VAPC_ADDR_DATA_PATH, 8'h00);
      fc(7'h04, 8'h0D);
      fc(7'h02, 8'h0B);
      mm(8'h00);
      {low_freq_status_in, repeater_in, backcompat_in} = 3'h7;
      wr(VAPC_ADDR_GEN_PURP, 8'hFF);
      repeat (4) @(negedge clk_in);
      rd(VAPC_ADDR_GEN_PURP, 8'hFF, 8'h9F);
      mm(8'hC0);
      wr(VAPC_ADDR_GEN_PURP, 8'h80);
      #1;
      chk(outs & 8'hC0, 8'h40);
      // Mismatch and clearing write in one cycle: the set must win
      @(negedge clk_in);
      reg_addr_in = VAPC_ADDR_GEN_PURP;
      reg_wdata_in = 8'h80;
      reg_wr_in = 1'b1;
      cksum_mismatch_in = 1'b1;
      @(negedge clk_in);
      {reg_wr_in, cksum_mismatch_in} = 2'b00;
      #1;
      chk(outs & 8'hC0, 8'hC0);
      // Second reset in mid-run
      @(negedge clk_in);
      nrst_in = 1'b0;
      @(negedge clk_in);
      nrst_in = 1'b1;
      #1;
      chk(outs, 8'h08);
      repeat (4) @(negedge clk_in);
      rd(VAPC_ADDR_GEN_PURP, 8'hFF, 8'h1F);
      end_sim;
   end
endmodule : tb_top
`default_nettype wire
